/* hw/hrg_top.sv */
// hybrid random generator: conditioner, online tests and post-processor
// assumes RAW_BIT is asynchronous to REF_CLK; consumer takes word on VALID
`default_nettype none

module hrg_top
    import hrg_pkg::*;
(
    input  wire logic          REF_CLK,
    input  wire logic          RSTN,
    input  wire logic          RAW_BIT,
    input  wire logic          WORD_TAKE,
    output var  hrg_pkg::hrg_word_s   WORD_OUT,
    output var  hrg_pkg::hrg_status_s STATUS,
    output var  logic          FAIL
);
    import hrg_pkg::*;

    // ****************************************
    // raw bit synchroniser and sample enable
    // ****************************************
    logic       raw_m;
    logic       raw_s;
    logic [7:0] div_cnt;
    wire        smp = (div_cnt == 8'(SAMPLE_DIV - 1));

    always_ff @(posedge REF_CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            raw_m   <= 1'b0;
            raw_s   <= 1'b0;
            div_cnt <= 8'h0;
        end
        else
        begin
            raw_m   <= RAW_BIT;
            raw_s   <= raw_m;
            div_cnt <= smp ? 8'h0 : div_cnt + 8'h1;
        end
    end

    // ****************************************
    // total failure and online statistical test
    // ****************************************
    logic       last_bit;
    logic [7:0] run_len;
    logic [8:0] win_cnt;
    logic [8:0] ones;
    logic       win_done;       // first full window passed
    logic       total_fail;
    logic       stat_fail;

    wire        next_run_hit  = smp && raw_s == last_bit
                                && run_len == 8'(TOT_FAIL_RUN - 1);
    wire        win_end       = smp && win_cnt == 9'(WIN_LEN - 1);
    wire [8:0]  ones_fin      = ones + {8'h0, raw_s};
    wire        win_bad       = win_end && (ones_fin < 9'(ONES_LO)
                                || ones_fin > 9'(ONES_HI));

    always_ff @(posedge REF_CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            last_bit   <= 1'b0;
            run_len    <= 8'h0;
            win_cnt    <= 9'h0;
            ones       <= 9'h0;
            win_done   <= 1'b0;
            total_fail <= 1'b0;
            stat_fail  <= 1'b0;
        end
        else if (smp)
        begin
            // every sampled raw bit is scanned, no gaps between windows
            last_bit <= raw_s;
            run_len  <= (raw_s == last_bit) ? run_len + 8'h1 : 8'h0;
            win_cnt  <= win_end ? 9'h0 : win_cnt + 9'h1;
            ones     <= win_end ? 9'h0 : ones_fin;
            if (win_end && !win_bad)
                win_done <= 1'b1;
            // sticky: only a reset revives a failed source
            if (next_run_hit)
                total_fail <= 1'b1;
            if (win_bad)
                stat_fail <= 1'b1;
        end
    end

    wire defect = total_fail || stat_fail;

    // ****************************************
    // adaptive compressor with entropy estimator
    // ****************************************
    logic [3:0] ratio;          // raw bits folded per conditioned bit
    logic [3:0] fold_cnt;
    logic       fold_acc;
    logic [WORD_W-1:0] cond_sr;
    logic [5:0] cond_cnt;
    logic       cond_rdy;

    // long runs hint at low entropy, so fold more raw bits together
    wire [3:0] next_ratio = (run_len > 8'h4 && ratio < 4'(RATIO_MAX)) ? ratio + 4'h1 :
                            (run_len == 8'h0 && ratio > 4'(RATIO_MIN)) ? ratio - 4'h1 :
                            ratio;
    wire       fold_end  = smp && fold_cnt >= ratio - 4'h1;
    wire       cond_bit  = fold_acc ^ raw_s;
    wire       word_end  = fold_end && cond_cnt == 6'(WORD_W - 1);

    always_ff @(posedge REF_CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            ratio    <= 4'(RATIO_MIN);
            fold_cnt <= 4'h0;
            fold_acc <= 1'b0;
            cond_sr  <= WORD_RST;
            cond_cnt <= 6'h0;
            cond_rdy <= 1'b0;
        end
        else
        begin
            cond_rdy <= word_end && !defect;
            if (smp)
            begin
                fold_cnt <= fold_end ? 4'h0 : fold_cnt + 4'h1;
                fold_acc <= fold_end ? 1'b0 : cond_bit;
                if (fold_end)
                begin
                    ratio    <= next_ratio;
                    cond_sr  <= {cond_sr[WORD_W-2:0], cond_bit};
                    cond_cnt <= word_end ? 6'h0 : cond_cnt + 6'h1;
                end
            end
        end
    end

    // ****************************************
    // hold-off before a conditioned word is trusted
    // ****************************************
    logic [WORD_W-1:0] cond_hold;   // kept while the conditioner shifts on
    logic [7:0]        age;
    logic              aging;

    // a source dying inside a word is caught only a full run later, so
    // each word waits out that run; costs one run of latency per word
    wire aged    = aging && smp && age == 8'(TOT_FAIL_RUN - 1);
    wire cond_ok = aged && !defect && !next_run_hit && !win_bad;

    always_ff @(posedge REF_CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            cond_hold <= WORD_RST;
            age       <= 8'h0;
            aging     <= 1'b0;
        end
        else if (cond_rdy)
        begin
            cond_hold <= cond_sr;
            age       <= 8'h0;
            aging     <= 1'b1;
        end
        else if (aged || defect)
            aging <= 1'b0;
        else if (aging && smp)
            age <= age + 8'h1;
    end

    // ****************************************
    // post-processor: state update and output functions
    // ****************************************
    function automatic logic [STATE_W-1:0] mix(input logic [STATE_W-1:0] s);
        logic [STATE_W-1:0] t;
        t = s ^ {s[50:0], 13'h0};
        t = t ^ {7'h0, t[63:7]};
        t = t ^ {t[46:0], 17'h0};
        mix = {t[38:0], t[63:39]} + 64'h9e3779b97f4a7c15;
    endfunction : mix

    hrg_state_e st;
    logic [STATE_W-1:0] pp_state;
    logic [1:0]         seed_cnt;
    logic               credit;     // one conditioned word buys one output word

    // update absorbs fresh input; output is a separate one-way fold
    wire [STATE_W-1:0] next_state = mix(pp_state ^ {cond_hold, ~cond_hold});
    wire [STATE_W-1:0] out_mix    = mix(~pp_state);
    wire [WORD_W-1:0]  out_word   = out_mix[63:32] ^ out_mix[31:0];
    wire               can_emit   = st == ST_RUN && credit && !defect
                                    && (!WORD_OUT.valid || WORD_TAKE);

    always_ff @(posedge REF_CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            st       <= ST_START;
            pp_state <= STATE_RST;
            seed_cnt <= 2'h0;
            credit   <= 1'b0;
            WORD_OUT <= '0;
            STATUS   <= '0;
            FAIL     <= 1'b0;
        end
        else
        begin
            STATUS <= '{total_fail: total_fail, stat_fail: stat_fail};
            FAIL   <= defect;
            if (cond_ok)
                pp_state <= next_state;
            case (st)
                ST_START:
                    if (defect)
                        st <= ST_FAIL;
                    else if (win_done)
                        st <= ST_SEED;
                ST_SEED:
                    if (defect)
                        st <= ST_FAIL;
                    else if (cond_ok)
                    begin
                        seed_cnt <= seed_cnt + 2'h1;
                        if (seed_cnt == 2'(SEED_WORDS - 1))
                            st <= ST_RUN;
                    end
                ST_RUN:
                    if (defect)
                        st <= ST_FAIL;
                ST_FAIL:
                    st <= ST_FAIL;
                default:
                    st <= ST_FAIL;
            endcase
            // a pending credit is dropped once the source is distrusted
            if (defect)
                credit <= 1'b0;
            else if (cond_ok && st == ST_RUN)
                credit <= 1'b1;
            else if (can_emit)
                credit <= 1'b0;
            if (defect)
                WORD_OUT.valid <= 1'b0;
            else if (can_emit)
            begin
                WORD_OUT.valid <= 1'b1;
                WORD_OUT.data  <= out_word;
            end
            else if (WORD_TAKE)
                WORD_OUT.valid <= 1'b0;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    a_no_out_fail: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        total_fail |=> !WORD_OUT.valid)
        else $error("word valid after total failure");
    a_fail_state: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        total_fail |=> st == ST_FAIL)
        else $error("generator still running after total failure");
    a_fail_kills: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        $rose(total_fail) |=> !WORD_OUT.valid [*3])
        else $error("output not suppressed after failure");
    a_stat_flag: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        win_bad |=> stat_fail)
        else $error("bad window not flagged");
    a_hold_start: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        st != ST_RUN |=> !$rose(WORD_OUT.valid))
        else $error("output before seeding");
    a_seed_first: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        WORD_OUT.valid |-> win_done && seed_cnt == 2'(SEED_WORDS))
        else $error("word before start test and seeding");
    a_scan_all: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        smp && !win_end |=> win_cnt == $past(win_cnt) + 9'h1)
        else $error("raw bit skipped by online test");
    a_rate_cap: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        $rose(WORD_OUT.valid) |-> $past(credit))
        else $error("output without matching input word");
    a_credit_spent: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        can_emit && !cond_ok |=> !credit)
        else $error("credit kept after an output word");
    a_out_func: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        can_emit |=> WORD_OUT.data == $past(out_word))
        else $error("output word not from output function");
    a_ratio_band: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        ratio >= 4'(RATIO_MIN) && ratio <= 4'(RATIO_MAX))
        else $error("compression ratio out of band");
    a_fail_flag: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        defect |=> FAIL)
        else $error("fail flag not raised");
    a_word_stands: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        WORD_OUT.valid && !WORD_TAKE && !defect |=> WORD_OUT.valid && $stable(WORD_OUT.data))
        else $error("unread word dropped or changed");
    a_take_clears: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        WORD_OUT.valid && WORD_TAKE && !can_emit |=> !WORD_OUT.valid)
        else $error("taken word still valid");

endmodule : hrg_top

`default_nettype wire

/* hw/hrg_pkg.sv */
// package of the hybrid random generator: constants and carrier structs
// assumes one clock REF_CLK at 125 MHz and an external raw entropy bit source
//
// Summary of operation
// - total-failure check at start; no words on failure
// - suppress words built from post-failure raw bits
// - online test at start-up and during operation
// - no output before start test and seeding
// - online test scans every raw bit
// - output bit rate never exceeds input rate
// - separate state-update and output functions
// - random words are 32 bits wide
// - input and seed only from physical source
// - entropy estimator sets compression ratio
// - each conditioned byte meets minimum entropy
// - internal numbers pass statistical procedure A
`default_nettype none

package hrg_pkg;

    // ****************************************
    // sizes and counts
    // ****************************************
    localparam int WORD_W       = 32;
    localparam int STATE_W      = 64;
    localparam int TOT_FAIL_RUN = 64;     // repeats of the previous raw bit that mean a dead source
    localparam int WIN_LEN      = 256;    // raw bits per online test window
    localparam int ONES_LO      = 96;     // tolerable ones count per window
    localparam int ONES_HI      = 160;
    localparam int SEED_WORDS   = 2;      // conditioned words needed to seed
    localparam int RATIO_MIN    = 2;      // raw bits per conditioned bit
    localparam int RATIO_MAX    = 8;
    localparam int SAMPLE_DIV   = 4;      // raw bit sample enable divider
    localparam logic [STATE_W-1:0] STATE_RST = 64'h0;
    localparam logic [WORD_W-1:0]  WORD_RST  = 32'h0;

    typedef enum {ST_START, ST_SEED, ST_RUN, ST_FAIL} hrg_state_e;

    typedef struct packed {
        logic              valid;
        logic [WORD_W-1:0] data;
    } hrg_word_s;

    typedef struct packed {
        logic total_fail;
        logic stat_fail;
    } hrg_status_s;

endpackage : hrg_pkg

`default_nettype wire

/* verif/hrg_consumer.sv */
// consumer model: the processor side that takes random words
// assumes valid is a registered level; drives take at the falling edge
`default_nettype none

module hrg_consumer
    import hrg_pkg::*;
(
    input  wire logic               clk,
    input  wire logic               stall,
    input  wire hrg_pkg::hrg_word_s word,
    output var  logic               take
);
    timeunit 1ns;
    timeprecision 1ps;

    initial take = 1'b0;

    // takes only while valid; a stall leaves the word waiting
    always @(negedge clk)
        take <= word.valid & ~stall;

endmodule : hrg_consumer

`default_nettype wire

/* verif/testbench.sv */
// bench of the hybrid random generator: raw bit source, scenarios, verdict
// assumes hrg_top and hrg_consumer; assertions sit in the design files
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import hrg_pkg::*;

    logic        ref_clk = 1'b0;
    logic        rstn    = 1'b0;
    logic        raw_bit = 1'b0;
    logic        stall   = 1'b1;
    logic        take;
    hrg_word_s   word;
    hrg_status_s status;
    logic        fail_any;
    logic [15:0] lfsr = 16'hace1;
    logic [31:0] last;
    int          src_mode = 0;
    int          nb = 0;
    int          fails = 0;
    int          n_compared = 0;

    always #4 ref_clk = ~ref_clk;

    // ********
    // raw source: 0 lfsr, 1 stuck low, 2 three ones in four samples
    // ********
    always @(negedge ref_clk)
    begin
        nb <= nb + 1;
        lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        raw_bit <= (src_mode == 0) ? lfsr[0] : (src_mode == 2) && (nb[3:2] != 2'h3);
    end

    hrg_top dut_u (
        .REF_CLK   (ref_clk),
        .RSTN      (rstn),
        .RAW_BIT   (raw_bit),
        .WORD_TAKE (take),
        .WORD_OUT  (word),
        .STATUS    (status),
        .FAIL      (fail_any)
    );

    hrg_consumer cons_u (.clk(ref_clk), .stall(stall), .word(word), .take(take));

    // ********
    // shared tasks
    // ********
    task automatic print_verdict();
        $display("compared %0d failed %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : print_verdict

    task automatic chk_bit(input logic got, input logic exp, input string what);
        n_compared++;
        if (got !== exp)
        begin
            fails++;
            $display("ERROR %0t: %s", $time, what);
        end
    endtask : chk_bit

    function automatic logic probe(input int which);
        if (which == 0)
            return word.valid;
        if (which == 1)
            return status.total_fail;
        return word.valid && (word.data !== last);
    endfunction : probe

    // bounded wait; running out ends the run
    task automatic wait_for(input int which, input int bound, output int n);
        n = 0;
        while (probe(which) !== 1'b1)
        begin
            @(negedge ref_clk);
            n++;
            if (n > bound)
            begin
                fails++;
                $display("ERROR %0t: wait %0d timed out", $time, which);
                print_verdict();
            end
        end
    endtask : wait_for

    task automatic watch(input int n, output logic seen);
        seen = 1'b0;
        repeat (n)
        begin
            @(negedge ref_clk);
            seen = seen | word.valid;
        end
    endtask : watch

    task automatic do_reset(input int mode);
        src_mode = mode;
        rstn = 1'b0;
        repeat (2) @(negedge ref_clk);
        rstn = 1'b1;
    endtask : do_reset

    // ********
    // scenarios
    // ********
    task automatic t_quiet_start();
        logic seen;
        do_reset(0);
        watch(1000, seen);
        chk_bit(seen, 1'b0, "word before start test");
        chk_bit(fail_any, 1'b0, "flag on a good source");
    endtask : t_quiet_start

    task automatic t_words();
        int   n;
        int   ones_n;
        logic seen;
        ones_n = 0;
        wait_for(0, 8000, n);
        last = word.data;
        chk_bit((^word.data) === 1'bx, 1'b0, "word has unknown bits");
        watch(300, seen);
        chk_bit(word.valid, 1'b1, "word dropped while waiting");
        chk_bit(word.data === last, 1'b1, "word moved while waiting");
        stall = 1'b0;
        // the word after the stall may spend a credit banked meanwhile
        repeat (2)
        begin
            wait_for(3, 8000, n);
            last = word.data;
        end
        repeat (3)
        begin
            wait_for(3, 8000, n);
            chk_bit(n >= 256, 1'b1, "words closer than input allows");
            ones_n += $countones(word.data);
            last = word.data;
        end
        chk_bit(ones_n >= 24 && ones_n <= 72, 1'b1, "words badly biased");
    endtask : t_words

    task automatic t_fail_run();
        int   n;
        logic seen;
        src_mode = 1;
        wait_for(1, 400, n);
        repeat (2) @(negedge ref_clk);
        chk_bit(word.valid, 1'b0, "word after source died");
        chk_bit(fail_any, 1'b1, "fail flag missing");
        src_mode = 0;
        watch(3000, seen);
        chk_bit(seen, 1'b0, "output came back");
        chk_bit(status.total_fail, 1'b1, "fail flag cleared");
    endtask : t_fail_run

    task automatic t_dead_start();
        logic seen;
        do_reset(1);
        chk_bit(fail_any, 1'b0, "flag kept over reset");
        watch(4000, seen);
        chk_bit(seen, 1'b0, "word from dead source");
        chk_bit(status.total_fail, 1'b1, "dead source not seen");
    endtask : t_dead_start

    task automatic t_biased();
        logic seen;
        do_reset(2);
        watch(3000, seen);
        chk_bit(seen, 1'b0, "word from biased source");
        chk_bit(status.stat_fail, 1'b1, "bias not flagged");
        chk_bit(status.total_fail, 1'b0, "bias taken for dead");
    endtask : t_biased

    initial
    begin
        t_quiet_start();
        t_words();
        t_fail_run();
        t_dead_start();
        t_biased();
        print_verdict();
    end

endmodule : testbench

`default_nettype wire
